// File: rtl/oam_cc_pkg.sv
// Purpose: Shared constants and carriers for the continuity check engine
// Assumes: One core clock; AHB-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses of aligned words
package oam_cc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_IRQ_ENA  = 8'h04;
    localparam logic [7:0] ADDR_STICKY   = 8'h08;
    localparam logic [7:0] ADDR_TX_SEQ   = 8'h0c;
    localparam logic [7:0] ADDR_RX_SEQ   = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_TLV      = 8'h18;
    localparam logic [7:0] ADDR_VLD_CNT  = 8'h1c;
    localparam logic [7:0] ADDR_INV_CNT  = 8'h20;
    localparam logic [7:0] ADDR_OOS_CNT  = 8'h24;
    localparam logic [7:0] ADDR_FLAGS    = 8'h28;
    localparam logic [7:0] ADDR_THRESH   = 8'h2c;
    // Control register fields
    localparam int C_HW_EN     = 0;
    localparam int C_LM_EN     = 1;
    localparam int C_SEQ_UPD   = 2;
    localparam int C_SEQ_CHK   = 3;
    localparam int C_TX_RDI    = 4;
    localparam int C_COPY_PL   = 5;
    localparam int C_COPY_LM   = 6;
    localparam int C_OAM_CNT   = 7;
    localparam int C_LM_OAM    = 8;
    localparam int C_DATA_CNT  = 9;
    localparam int C_PERIOD    = 10;
    localparam int C_LM_TIMER  = 13;
    localparam int CTRL_W      = 16;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
    // Sticky and interrupt enable bit positions
    localparam int S_CC_RX   = 0;
    localparam int S_LM_RX   = 1;
    localparam int S_SEQ_ERR = 2;
    localparam int S_RDI     = 3;
    localparam int S_LOC     = 4;
    localparam int S_SRC     = 5;
    localparam int S_PORT    = 6;
    localparam int S_IF      = 7;
    localparam int STICKY_W  = 8;
    // Flags register bits
    localparam int F_EXTRACT = 0;
    localparam int F_INSERT  = 1;
    localparam logic [2:0] MISS_MAX   = 3'h7;
    localparam logic [7:0] TLV_END    = 8'h00;
    localparam logic [7:0] TLV_PORT   = 8'h02;
    localparam logic [7:0] TLV_IF     = 8'h04;
    localparam logic [7:0] THRESH_RST = 8'h03;

    typedef struct packed {
        logic [31:0] seq;
        logic        rdi;
        logic        lm_nonzero;
    } tx_in_s;

    typedef struct packed {
        logic [31:0] seq;
        logic        rdi;
        logic        lm_insert;
        logic        oam_count;
        logic        data_count;
    } tx_out_s;

    typedef struct packed {
        logic [31:0] seq;
        logic        rdi;
        logic [2:0]  period;
        logic        lm_nonzero;
        logic [3:0]  src_port;
        logic        on_lag;
        logic [3:0]  member_port;
        logic [7:0]  tlv_type0;
        logic [7:0]  tlv_type1;
        logic [7:0]  port_status;
        logic [7:0]  if_status;
    } rx_in_s;

    typedef struct packed {
        logic valid;
        logic copy_cpu;
        logic oam_count;
        logic data_count;
        logic lm;
        logic end_tlv_nonzero;
        logic seq_err;
    } rx_out_s;
endpackage : oam_cc_pkg

// File: rtl/continuity_check_oam_engine.sv
// Purpose: Continuity check processing for one OAM endpoint
// Assumes: Frame pipeline and timer controller run on hclk
// Notes:   Reads take one wait state, writes none
// What this block does
// - Hardware enable clear: pass PDUs unmodified, skip receive checks; miss counter still steps on expiry.
// - Sequence update enabled: outgoing sequence replaced by stored transmit value.
// - Every valid outgoing PDU with hardware enable set bumps stored transmit sequence by one.
// - Outgoing defect indication replaced by configured transmit value.
// - Valid receive sets receive flag, and loss flag when loss-carrying.
// - Sequence check: mismatch to stored plus one sets flag, counts.
// - Received sequence number becomes the stored receive sequence.
// - Defect indication change sets flag, interrupt if enabled, then stored.
// - Valid receive resets miss counter to zero.
// - Valid receive during loss state sets flag and clears state.
// - Separate counters for valid and invalid received PDUs.
// - Copy to processor: next-one flag or copy-all enables.
// - Generic and data counting follow their separate enables.
// - Record source port; member port when arriving on aggregate.
// - Count same-port PDUs; at threshold set flag and interrupt.
// - Different source port resets the same-port counter.
// - Status TLVs parsed only as leading TLVs; others stop parsing.
// - Store status values; change sets flag and interrupt.
// - Three-bit miss counter steps on each selected timer expiry up to seven, then holds.
// - Miss count seven sets loss state; state change sets flag.
// - Insert-next flag adds loss data to next PDU, then clears.
// - One period selection picks timer and validates received period.
// - Loss-carrying needs both enables and a non-zero payload counter, or on transmit a pending insert-next flag.
module continuity_check_oam_engine (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                tx_valid,
    input  wire oam_cc_pkg::tx_in_s  tx_in,
    output logic                     tx_out_valid,
    output oam_cc_pkg::tx_out_s      tx_out,
    input  wire logic                rx_valid,
    input  wire oam_cc_pkg::rx_in_s  rx_in,
    output logic                     rx_out_valid,
    output oam_cc_pkg::rx_out_s      rx_out,
    input  wire logic [7:0]          timer_expiry,
    output logic                     irq
);
    import oam_cc_pkg::*;

    logic [CTRL_W-1:0]   ctrl;
    logic [STICKY_W-1:0] irq_ena;
    logic [STICKY_W-1:0] sticky;
    logic [31:0]         tx_seq;
    logic [31:0]         rx_seq;
    logic [31:0]         vld_cnt;
    logic [31:0]         inv_cnt;
    logic [31:0]         oos_cnt;
    logic [7:0]          thresh;
    logic                extract_next;
    logic                insert_next;
    logic [2:0]          miss_cnt;
    logic                loc;
    logic                last_rdi;
    logic [3:0]          last_src;
    logic [7:0]          same_src;
    logic [7:0]          port_st;
    logic [7:0]          if_st;
    logic                wr_pend;
    logic                rd_pend;
    logic [7:0]          acc_addr;

    logic                hw_en;
    logic                tx_go;
    logic                rx_ok;
    logic                rx_bad;
    logic                rx_lm;
    logic                tx_lm;
    logic                seq_err;
    logic                miss_tick;
    logic                lm_tick;
    logic [3:0]          src_now;
    logic                t0_port;
    logic                t0_if;
    logic                t0_stat;
    logic                t1_port;
    logic                t1_if;
    logic                end_nz;
    logic                port_upd;
    logic                if_upd;
    logic [STICKY_W-1:0] hw_set;
    logic [STICKY_W-1:0] sw_clr;
    logic                wr_ctrl;
    logic                wr_ena;
    logic                wr_stk;
    logic                wr_txs;
    logic                wr_rxs;
    logic                wr_vld;
    logic                wr_inv;
    logic                wr_oos;
    logic                wr_flg;
    logic                wr_thr;

    assign hw_en     = ctrl[C_HW_EN];
    assign tx_go     = tx_valid && hw_en;
    assign rx_ok     = rx_valid && hw_en && (rx_in.period == ctrl[C_PERIOD+:3]);
    assign rx_bad    = rx_valid && hw_en && !rx_ok;
    assign rx_lm     = hw_en && ctrl[C_LM_EN] && rx_in.lm_nonzero;
    assign tx_lm     = hw_en && ctrl[C_LM_EN] && (tx_in.lm_nonzero || insert_next);
    assign seq_err   = ctrl[C_SEQ_CHK] && (rx_in.seq != rx_seq + 32'h1);
    assign miss_tick = timer_expiry[ctrl[C_PERIOD+:3]];
    assign lm_tick   = timer_expiry[ctrl[C_LM_TIMER+:3]];
    assign src_now   = rx_in.on_lag ? rx_in.member_port : rx_in.src_port;

    // status TLVs only as leading ones
    assign t0_port  = rx_in.tlv_type0 == TLV_PORT;
    assign t0_if    = rx_in.tlv_type0 == TLV_IF;
    assign t0_stat  = t0_port || t0_if;
    assign t1_port  = t0_if && rx_in.tlv_type1 == TLV_PORT;
    assign t1_if    = t0_port && rx_in.tlv_type1 == TLV_IF;
    assign end_nz   = t0_stat ? (rx_in.tlv_type1 != TLV_END && !t1_port && !t1_if)
                              : (rx_in.tlv_type0 != TLV_END);
    assign port_upd = rx_ok && (t0_port || t1_port);
    assign if_upd   = rx_ok && (t0_if || t1_if);

    // Bus write decode, applied in the data phase
    assign wr_ctrl = wr_pend && acc_addr == ADDR_CTRL;
    assign wr_ena  = wr_pend && acc_addr == ADDR_IRQ_ENA;
    assign wr_stk  = wr_pend && acc_addr == ADDR_STICKY;
    assign wr_txs  = wr_pend && acc_addr == ADDR_TX_SEQ;
    assign wr_rxs  = wr_pend && acc_addr == ADDR_RX_SEQ;
    assign wr_vld  = wr_pend && acc_addr == ADDR_VLD_CNT;
    assign wr_inv  = wr_pend && acc_addr == ADDR_INV_CNT;
    assign wr_oos  = wr_pend && acc_addr == ADDR_OOS_CNT;
    assign wr_flg  = wr_pend && acc_addr == ADDR_FLAGS;
    assign wr_thr  = wr_pend && acc_addr == ADDR_THRESH;
    assign sw_clr  = wr_stk ? hwdata[STICKY_W-1:0] : '0;

    always_comb begin
        hw_set = '0;
        hw_set[S_CC_RX]   = rx_ok;
        hw_set[S_LM_RX]   = rx_ok && rx_lm;
        hw_set[S_SEQ_ERR] = rx_ok && seq_err;
        hw_set[S_RDI]     = rx_ok && (rx_in.rdi != last_rdi);
        hw_set[S_LOC]     = (rx_ok && loc) || (!rx_ok && !loc && miss_tick
                            && miss_cnt == MISS_MAX - 3'h1);
        hw_set[S_SRC]     = rx_ok && src_now == last_src && same_src + 8'h1 == thresh;
        hw_set[S_PORT]    = port_upd && (rx_in.port_status != port_st);
        hw_set[S_IF]      = if_upd && (rx_in.if_status != if_st);
    end

    // Write-one-to-clear; a same-cycle event wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sticky <= '0;
        end else begin
            sticky <= (sticky & ~sw_clr) | hw_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(sticky & irq_ena);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl    <= CTRL_RST;
            irq_ena <= '0;
            thresh  <= THRESH_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata[CTRL_W-1:0];
            end
            if (wr_ena) begin
                irq_ena <= hwdata[STICKY_W-1:0];
            end
            if (wr_thr) begin
                thresh <= hwdata[7:0];
            end
        end
    end

    // Transmit path: one cycle through, fields rewritten only when enabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_out_valid <= 1'b0;
            tx_out       <= '0;
        end else begin
            tx_out_valid <= tx_valid;
            if (tx_valid) begin
                tx_out.seq        <= tx_in.seq;
                tx_out.rdi        <= tx_in.rdi;
                tx_out.lm_insert  <= 1'b0;
                tx_out.oam_count  <= tx_lm ? ctrl[C_LM_OAM] : ctrl[C_OAM_CNT];
                tx_out.data_count <= ctrl[C_DATA_CNT];
                if (tx_go) begin
                    if (ctrl[C_SEQ_UPD]) begin
                        tx_out.seq <= tx_seq;
                    end
                    tx_out.rdi       <= ctrl[C_TX_RDI];
                    tx_out.lm_insert <= insert_next;
                end
            end
        end
    end

    // Software write wins over a same-cycle increment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_seq <= '0;
        end else if (wr_txs) begin
            tx_seq <= hwdata;
        end else if (tx_go) begin
            tx_seq <= tx_seq + 32'h1;
        end
    end

    // A set, by software or timer, wins over the clear on use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            insert_next  <= 1'b0;
            extract_next <= 1'b0;
        end else begin
            // set by software or timer, cleared on insertion
            if ((wr_flg && hwdata[F_INSERT]) || lm_tick) begin
                insert_next <= 1'b1;
            end else if (tx_go) begin
                insert_next <= 1'b0;
            end
            if (wr_flg && hwdata[F_EXTRACT]) begin
                extract_next <= 1'b1;
            end else if (rx_ok) begin
                extract_next <= 1'b0;
            end
        end
    end

    // Receive result, one cycle after the request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_out_valid <= 1'b0;
            rx_out       <= '0;
        end else begin
            rx_out_valid <= rx_valid;
            if (rx_valid) begin
                // disabled engine passes frames as valid
                rx_out.valid           <= rx_ok || !hw_en;
                rx_out.copy_cpu        <= rx_ok && (extract_next
                                          || (rx_lm ? ctrl[C_COPY_LM] : ctrl[C_COPY_PL]));
                rx_out.oam_count       <= rx_lm ? ctrl[C_LM_OAM] : ctrl[C_OAM_CNT];
                rx_out.data_count      <= ctrl[C_DATA_CNT];
                rx_out.lm              <= rx_lm;
                rx_out.end_tlv_nonzero <= rx_ok && end_nz;
                rx_out.seq_err         <= rx_ok && seq_err;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_seq   <= '0;
            last_rdi <= 1'b0;
        end else if (rx_ok) begin
            rx_seq   <= rx_in.seq;
            last_rdi <= rx_in.rdi;
        end else if (wr_rxs) begin
            rx_seq <= hwdata;
        end
    end

    // valid and invalid counters; writing clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vld_cnt <= '0;
            inv_cnt <= '0;
            oos_cnt <= '0;
        end else begin
            if (wr_vld) begin
                vld_cnt <= '0;
            end else if (rx_ok) begin
                vld_cnt <= vld_cnt + 32'h1;
            end
            if (wr_inv) begin
                inv_cnt <= '0;
            end else if (rx_bad) begin
                inv_cnt <= inv_cnt + 32'h1;
            end
            if (wr_oos) begin
                oos_cnt <= '0;
            end else if (rx_ok && seq_err) begin
                oos_cnt <= oos_cnt + 32'h1;
            end
        end
    end

    // A valid frame beats a same-cycle expiry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            miss_cnt <= '0;
            loc      <= 1'b0;
        end else if (rx_ok) begin
            miss_cnt <= '0;
            loc      <= 1'b0;
        end else if (miss_tick && miss_cnt != MISS_MAX) begin
            miss_cnt <= miss_cnt + 3'h1;
            if (miss_cnt == MISS_MAX - 3'h1) begin
                loc <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_src <= '0;
            same_src <= '0;
        end else if (rx_ok) begin
            // record port, restart count on move
            last_src <= src_now;
            if (src_now != last_src) begin
                same_src <= '0;
            end else if (same_src != 8'hff) begin
                same_src <= same_src + 8'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_st <= '0;
            if_st   <= '0;
        end else begin
            if (port_upd) begin
                port_st <= rx_in.port_status;
            end
            if (if_upd) begin
                if_st <= rx_in.if_status;
            end
        end
    end

    // Bus slave: reads wait one cycle so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            acc_addr  <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            if (rd_pend) begin
                hreadyout <= 1'b1;
                unique case (acc_addr)
                    ADDR_CTRL:    hrdata <= {16'h0, ctrl};
                    ADDR_IRQ_ENA: hrdata <= {24'h0, irq_ena};
                    ADDR_STICKY:  hrdata <= {24'h0, sticky};
                    ADDR_TX_SEQ:  hrdata <= tx_seq;
                    ADDR_RX_SEQ:  hrdata <= rx_seq;
                    ADDR_STATUS:  hrdata <= {8'h0, same_src, 4'h0, last_src,
                                             3'h0, last_rdi, loc, miss_cnt};
                    ADDR_TLV:     hrdata <= {16'h0, if_st, port_st};
                    ADDR_VLD_CNT: hrdata <= vld_cnt;
                    ADDR_INV_CNT: hrdata <= inv_cnt;
                    ADDR_OOS_CNT: hrdata <= oos_cnt;
                    ADDR_FLAGS:   hrdata <= {30'h0, insert_next, extract_next};
                    ADDR_THRESH:  hrdata <= {24'h0, thresh};
                    default:      hrdata <= '0;
                endcase
            end else if (hsel && htrans[1] && hready) begin
                acc_addr <= haddr[7:0];
                wr_pend  <= hwrite;
                rd_pend  <= !hwrite;
                if (!hwrite) begin
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    a_tx_seq_step: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_go && !wr_txs) |=> tx_seq == $past(tx_seq) + 32'h1)
        else $error("transmit sequence did not step");

    a_tx_rdi_over: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_go |=> tx_out_valid && tx_out.rdi == $past(ctrl[C_TX_RDI]))
        else $error("transmit defect bit not replaced");

    a_tx_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_valid && !hw_en) |=> tx_out.seq == $past(tx_in.seq) && !tx_out.lm_insert)
        else $error("disabled frame was modified");

    a_miss_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_ok |=> miss_cnt == 3'h0 && !loc)
        else $error("miss counter not cleared");

    a_loc_enter: assert property (@(posedge hclk) disable iff (!hresetn)
        (!rx_ok && miss_tick && miss_cnt == 3'h6) |=> loc && sticky[S_LOC])
        else $error("loss state not entered");

    a_miss_sat: assert property (@(posedge hclk) disable iff (!hresetn)
        (miss_cnt == 3'h7 && !rx_ok) |=> miss_cnt == 3'h7 && loc)
        else $error("miss counter left saturation");

    a_seq_err: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_ok && seq_err && !wr_oos) |=> sticky[S_SEQ_ERR] && oos_cnt == $past(oos_cnt) + 32'h1)
        else $error("sequence error not recorded");

    a_ins_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (tx_go && insert_next && !lm_tick && !wr_flg) |=> tx_out.lm_insert && !insert_next)
        else $error("insert flag not consumed");

    a_src_move: assert property (@(posedge hclk) disable iff (!hresetn)
        (rx_ok && src_now != last_src) |=> same_src == 8'h0 && last_src == $past(src_now))
        else $error("source move not tracked");
endmodule : continuity_check_oam_engine

// File: tb/cc_far_side.sv
// Purpose: Frame pipeline and shared timer stand-in
// Assumes: Tasks are entered just after a rising hclk edge
// Notes:   Released payload shows the inverse of its last value
module cc_far_side (
    input  wire logic          hclk,
    output logic               tx_valid,
    output oam_cc_pkg::tx_in_s tx_in,
    output logic               rx_valid,
    output oam_cc_pkg::rx_in_s rx_in,
    output logic [7:0]         timer_expiry
);
    timeunit 1ns;
    timeprecision 1ns;
    import oam_cc_pkg::*;
    initial begin
        tx_valid     = 1'b0;
        tx_in        = '0;
        rx_valid     = 1'b0;
        rx_in        = '0;
        timer_expiry = 8'h00;
    end
    task automatic send_tx(input tx_in_s v);
        tx_valid <= 1'b1;
        tx_in    <= v;
        @(posedge hclk);
        tx_valid <= 1'b0;
        tx_in    <= ~v;
    endtask : send_tx
    task automatic send_rx(input rx_in_s v);
        rx_valid <= 1'b1;
        rx_in    <= v;
        @(posedge hclk);
        rx_valid <= 1'b0;
        rx_in    <= ~v;
    endtask : send_rx
    task automatic expire(input int t);
        timer_expiry[t] <= 1'b1;
        @(posedge hclk);
        timer_expiry    <= 8'h00;
    endtask : expire
endmodule : cc_far_side

// File: tb/continuity_check_oam_engine_tb_top.sv
// Purpose: Self-checking bench for the continuity check engine
// Assumes: Bus hready is the slave's hreadyout
// Notes:   Expectations come from small integer models of the state
module continuity_check_oam_engine_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import oam_cc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hresp, hrdy, tx_v, tx_ov, rx_v, rx_ov, irq;
    logic [31:0] haddr, hwdata, hrdata, rdv, t;
    logic [1:0]  htrans;
    logic [7:0]  tmr;
    tx_in_s      txi;
    tx_out_s     txo;
    rx_in_s      rxi, r;
    rx_out_s     rxo;
    int          miscompares, num_checks, m_tx, m_rx, m_oos, m_vld, i;
    cc_far_side m (.hclk(hclk), .tx_valid(tx_v), .tx_in(txi), .rx_valid(rx_v), .rx_in(rxi),
        .timer_expiry(tmr));
    continuity_check_oam_engine dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hrdy), .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .tx_valid(tx_v),
        .tx_in(txi), .tx_out_valid(tx_ov), .tx_out(txo), .rx_valid(rx_v), .rx_in(rxi),
        .rx_out_valid(rx_ov), .rx_out(rxo), .timer_expiry(tmr), .irq(irq));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        // Start on an edge so a request never follows an off-edge check
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        rdv = hrdata;
    endtask : bus
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
        bus(1'b0, a, 32'h0);
        chk("register", e, rdv & k);
        chk("hresp", 0, hresp);
    endtask : rc
    // Valid frames use period 3, the configured one
    task automatic do_rx(input logic [31:0] q, input logic [2:0] p, input logic d);
        r        = '0;
        r.seq    = q;
        r.period = p;
        r.rdi    = d;
        @(posedge hclk);
        m.send_rx(r);
        #1;
        chk("rx_out_valid", 1, rx_ov);
        chk("rx_valid_flag", 32'(p == 3'h3), rxo.valid);
        if (p == 3'h3) begin
            chk("seq_err", (q != 32'(m_rx + 1)), rxo.seq_err);
            chk("rx_flags", 32'h8, 32'(rxo[5:1]));
            m_oos += (q != 32'(m_rx + 1));
            m_rx = q;
            m_vld++;
        end
    endtask : do_rx
    task automatic give_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, miscompares, num_checks} = '0;
        {m_oos, m_vld} = '0;
        hresetn = 1'b0;
        void'($urandom(89051));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(ADDR_CTRL, 32'h0, 32'hffff_ffff);
        rc(ADDR_THRESH, 32'(THRESH_RST), 32'hff);
        rc(8'hfc, 32'h0, 32'hffff_ffff);
        t = $urandom;
        @(posedge hclk);
        m.send_tx('{t, 1'b1, 1'b0});
        #1 chk("tx_seq", t, txo.seq);
        rc(ADDR_TX_SEQ, 32'h0, 32'hffff_ffff);
        // Enable, lm, seq update, seq check, plain count, period 3, transmit defect 0
        bus(1'b1, ADDR_CTRL, 32'h0000_0c8f);
        m_tx = $urandom;
        bus(1'b1, ADDR_TX_SEQ, 32'(m_tx));
        bus(1'b1, ADDR_FLAGS, 32'h2);
        for (i = 0; i < 3; i++) begin
            @(posedge hclk);
            m.send_tx('{~t, 1'b1, 1'b0});
            #1 chk("tx_seq", m_tx, txo.seq);
            chk("tx_rdi", 0, txo.rdi);
            chk("lm_insert", (i == 0), txo.lm_insert);
            chk("tx_count", 32'({i != 0, 1'b0}), 32'(txo[1:0]));
            chk("tx_out_valid", 1, tx_ov);
            m_tx++;
        end
        rc(ADDR_TX_SEQ, m_tx, 32'hffff_ffff);
        m_rx = $urandom;
        bus(1'b1, ADDR_RX_SEQ, 32'(m_rx));
        do_rx(32'(m_rx + 1), 3'h3, 1'b0);
        do_rx(32'(m_rx + 2), 3'h3, 1'b0);
        do_rx(32'(m_rx + 1), 3'h5, 1'b0);
        rc(ADDR_RX_SEQ, m_rx, 32'hffff_ffff);
        rc(ADDR_OOS_CNT, m_oos, 32'hffff_ffff);
        rc(ADDR_VLD_CNT, m_vld, 32'hffff_ffff);
        rc(ADDR_INV_CNT, 1, 32'hffff_ffff);
        for (i = 0; i < 8; i++) begin
            @(posedge hclk);
            m.expire(3);
        end
        rc(ADDR_STATUS, 32'hf, 32'hf);
        do_rx(32'(m_rx + 1), 3'h3, 1'b1);
        rc(ADDR_STATUS, 32'h0, 32'hf);
        // Third same-port frame meets the default threshold of three
        rc(ADDR_STICKY, 32'h3d, 32'h3f);
        bus(1'b1, ADDR_IRQ_ENA, 32'h8);
        @(posedge hclk);
        #1 chk("irq", 1, irq);
        bus(1'b1, ADDR_FLAGS, 32'h1);
        r             = '0;
        r.seq         = 32'(m_rx + 1);
        r.period      = 3'h3;
        r.on_lag      = 1'b1;
        r.member_port = 4'h5;
        r.tlv_type0   = TLV_PORT;
        r.port_status = t[7:0];
        @(posedge hclk);
        m.send_rx(r);
        #1 chk("copy_cpu", 1, rxo.copy_cpu);
        rc(ADDR_TLV, {24'h0, r.port_status}, 32'hffff);
        rc(ADDR_STICKY, {25'h0, r.port_status != 8'h0, 6'h0}, 32'h40);
        rc(ADDR_STATUS, 32'h0000_0500, 32'h00ff_0f00);
        give_verdict();
    end
endmodule : continuity_check_oam_engine_tb_top
